// [rtl/pulse_motor_consts.svh]
// named constants for the pulse motor drive and status block
`ifndef PULSE_MOTOR_CONSTS_SVH
`define PULSE_MOTOR_CONSTS_SVH

// ----------------------------------------
// register port addresses
// ----------------------------------------
`define ADDR_CMD       3'h0
`define ADDR_DATA_HI   3'h1
`define ADDR_DATA_MID  3'h2
`define ADDR_DATA_LO   3'h3
`define ADDR_CFG       3'h4

// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_SPEED_SET  8'h08
`define CMD_SCAN_CW    8'h12
`define CMD_SCAN_CCW   8'h13
`define CMD_INDEX_INC  8'h14
`define CMD_INDEX_ABS  8'h15
`define CMD_ORG_DELAY  8'h1C
`define CMD_ORIGIN     8'h1E
`define CMD_FAST_STOP  8'h1F
`define CMD_CMP_SET    8'h20
`define CMD_SEL_COUNT  8'hFC
`define CMD_SEL_SPEED  8'hFD
`define CMD_SEL_CMP    8'hFE

// ----------------------------------------
// status and configuration bit positions
// ----------------------------------------
`define STAT_BUSY      0
`define STAT_DRIVE     1
`define STAT_ERROR     2
`define STAT_LIMIT_END 3
`define STAT_FAST_END  4
`define STAT_MATCH     5
`define CFG_SERVO      0

// ----------------------------------------
// reset values and field constants
// ----------------------------------------
`define COUNT_RESET    24'h000000
`define CMP_RESET      24'h800000
`define SPEED_RESET    24'h000F9F
`define DELAY_RESET    8'h00
`define CFG_RESET      8'h00
`define BYTE_ZERO      8'h00
`define WORD_ONE       24'h000001
`define ORG_TYPE_THREE 3'h3
`define ORG_TYPE_FIVE  3'h5
`define SIGN_BIT       23

// ----------------------------------------
// timing: one wait unit is 1 ms at 25 ns per clock
// ----------------------------------------
`define CLK_PERIOD_NS  25
`define WAIT_UNIT_NS   1000000

`endif

// [rtl/pulse_motor_pkg.sv]
// types shared by the pulse motor drive and status block
package pulse_motor_pkg;

  // drive sequencer states
  typedef enum logic [4:0] {
    ST_IDLE       = 5'b00001,
    ST_HOLD       = 5'b00010,
    ST_RUN        = 5'b00100,
    ST_DELAY      = 5'b01000,
    ST_SERVO_WAIT = 5'b10000
  } drive_state_e;

  // origin sequence phases
  typedef enum logic [3:0] {
    PH_SEEK   = 4'b0001,
    PH_SENSED = 4'b0010,
    PH_JOG    = 4'b0100,
    PH_FINAL  = 4'b1000
  } origin_phase_e;

  // source routed onto the three data ports
  typedef enum logic [2:0] {
    PORT_COUNT = 3'b001,
    PORT_SPEED = 3'b010,
    PORT_CMP   = 3'b100
  } port_sel_e;

  // kind of drive in progress
  typedef enum logic [2:0] {
    MODE_SCAN   = 3'b001,
    MODE_INDEX  = 3'b010,
    MODE_ORIGIN = 3'b100
  } drive_mode_e;

endpackage

// [rtl/in_sync.sv]
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none

module in_sync #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // pins and synchronised copies
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1_reg;

  // ----------------------------------------
  // one pair of flops per bit
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // first stage feeds only the second stage, nothing else
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          stage1_reg[i] <= 1'b0;
          syncOut[i]    <= 1'b0;
        end else begin
          stage1_reg[i] <= asyncIn[i];
          syncOut[i]    <= stage1_reg[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [rtl/step_rate_gen.sv]
// programmable divider giving a one-cycle tick every period+1 clocks
`timescale 1ns/10ps
`default_nettype none

module step_rate_gen (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // control
  input  wire logic        enable,
  input  wire logic [23:0] period,
  // output
  output logic             tick
);

  logic [23:0] cnt_reg;
  wire         wrap = (cnt_reg >= period);

  // ----------------------------------------
  // divider restarts whenever it is disabled
  // ----------------------------------------
  // restarting keeps the first step a full period after a start
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 24'h000000;
      tick    <= 1'b0;
    end else if (!enable) begin
      cnt_reg <= 24'h000000;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= wrap ? 24'h000000 : cnt_reg + 24'h000001;
      tick    <= wrap;
    end
  end

endmodule

`default_nettype wire

// [rtl/pulse_motor_drive_status.sv]
// pulse motor drive sequencer, pulse counter read path and status flags
`timescale 1ns/10ps
`default_nettype none
`include "pulse_motor_consts.svh"

module pulse_motor_drive_status #(
  parameter int unsigned WAIT_TICK_CYCLES = `WAIT_UNIT_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStrobe,
  input  wire logic       regRdStrobe,
  output logic      [7:0] regRdData,
  // motor side pins
  input  wire logic       limitCwIn,
  input  wire logic       limitCcwIn,
  input  wire logic       fastStopIn,
  input  wire logic       originSensorIn,
  input  wire logic       servoDriveEndIn,
  output logic            pulseCwOut,
  output logic            pulseCcwOut
);
  import pulse_motor_pkg::*;

  // ----------------------------------------
  // pin synchronisation and dividers
  // ----------------------------------------
  logic [4:0] pinSync;
  logic       stepTick;
  logic       waitTick;

  in_sync #(.W(5)) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .asyncIn ({servoDriveEndIn, originSensorIn, fastStopIn, limitCcwIn, limitCwIn}),
    .syncOut (pinSync)
  );

  wire limitCw  = pinSync[0];
  wire limitCcw = pinSync[1];
  wire fastStop = pinSync[2];
  wire sensorOn = pinSync[3];
  wire driveEnd = pinSync[4];

  drive_state_e  state_reg,  state_next;
  origin_phase_e phase_reg,  phase_next;
  drive_mode_e   mode_reg,   mode_next;
  port_sel_e     portSel_reg, portSel_next;
  logic [23:0]   count_reg,  count_next;
  logic [23:0]   cmp_reg,    cmp_next;
  logic [23:0]   speed_reg,  speed_next;
  logic [23:0]   remain_reg, remain_next;
  logic [23:0]   snap_reg,   snap_next;
  logic [7:0]    dataHi_reg, dataMid_reg, dataLo_reg;
  logic [7:0]    cfg_reg;
  logic [7:0]    limitWait_reg, scanWait_reg, jogWait_reg;
  logic [7:0]    waitCnt_reg, waitCnt_next;
  logic [2:0]    orgType_reg, orgType_next;
  logic          busy_reg, busy_next, drive_reg, drive_next;
  logic          error_reg, error_next, limitEnd_reg, limitEnd_next;
  logic          fastEnd_reg, fastEnd_next, match_reg, match_next;
  logic          dir_reg, dir_next, lastStep_reg, lastStep_next;
  logic          pulseCw_next, pulseCcw_next;

  // the wait divider only runs while the sequencer waits
  wire [23:0] waitPeriod = 24'(WAIT_TICK_CYCLES - 1);

  step_rate_gen u_step (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .enable  (state_reg == ST_RUN),
    .period  (speed_reg),
    .tick    (stepTick)
  );

  step_rate_gen u_wait (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .enable  (state_reg == ST_DELAY),
    .period  (waitPeriod),
    .tick    (waitTick)
  );

  // ----------------------------------------
  // address and command decode
  // ----------------------------------------
  wire        wrCmd    = regWrStrobe && (regAddr == `ADDR_CMD);
  wire        wrHi     = regWrStrobe && (regAddr == `ADDR_DATA_HI);
  wire        wrMid    = regWrStrobe && (regAddr == `ADDR_DATA_MID);
  wire        wrLo     = regWrStrobe && (regAddr == `ADDR_DATA_LO);
  wire        wrCfg    = regWrStrobe && (regAddr == `ADDR_CFG);
  wire        rdHi     = regRdStrobe && (regAddr == `ADDR_DATA_HI);
  wire [23:0] dataWord = {dataHi_reg, dataMid_reg, dataLo_reg};
  wire        servoOn  = cfg_reg[`CFG_SERVO];
  wire        isSelect = (regWrData == `CMD_SEL_COUNT) || (regWrData == `CMD_SEL_SPEED)
                         || (regWrData == `CMD_SEL_CMP);
  wire        isScan   = (regWrData == `CMD_SCAN_CW) || (regWrData == `CMD_SCAN_CCW);
  wire        isIndex  = (regWrData == `CMD_INDEX_INC) || (regWrData == `CMD_INDEX_ABS);
  wire        isOrigin = (regWrData == `CMD_ORIGIN);
  wire        isSetup  = (regWrData == `CMD_SPEED_SET) || (regWrData == `CMD_ORG_DELAY)
                         || (regWrData == `CMD_CMP_SET);

  // index distance: absolute target minus position, or the increment itself
  wire [23:0] delta    = (regWrData == `CMD_INDEX_ABS) ? dataWord - count_reg : dataWord;
  wire [23:0] absDelta = delta[`SIGN_BIT] ? 24'h000000 - delta : delta;
  wire        cmdDir   = isOrigin || (regWrData == `CMD_SCAN_CCW)
                         || (isIndex && delta[`SIGN_BIT]);
  wire        cmdLimit = cmdDir ? limitCcw : limitCw;
  wire        runLimit = dir_reg ? limitCcw : limitCw;
  wire        active   = (state_reg == ST_HOLD) || (state_reg == ST_RUN)
                         || (state_reg == ST_DELAY);
  wire        stopNow  = active && (fastStop || (wrCmd && regWrData == `CMD_FAST_STOP));
  wire        type35   = (orgType_reg == `ORG_TYPE_THREE) || (orgType_reg == `ORG_TYPE_FIVE);
  wire        counted  = (mode_reg == MODE_INDEX) || (phase_reg == PH_FINAL);

  // ----------------------------------------
  // read path: data ports show the routed source
  // ----------------------------------------
  wire [23:0] routeWord = (portSel_reg == PORT_COUNT) ? count_reg :
                          (portSel_reg == PORT_SPEED) ? speed_reg : cmp_reg;
  wire [7:0]  statusByte = {2'b00, match_reg, fastEnd_reg, limitEnd_reg,
                            error_reg, drive_reg, busy_reg};
  wire [7:0]  rdNext = (regAddr == `ADDR_CMD)      ? statusByte :
                       (regAddr == `ADDR_DATA_HI)  ? routeWord[23:16] :
                       (regAddr == `ADDR_DATA_MID) ? snap_reg[15:8] :
                       (regAddr == `ADDR_DATA_LO)  ? snap_reg[7:0] :
                       (regAddr == `ADDR_CFG)      ? cfg_reg : `BYTE_ZERO;

  // lower bytes are frozen when the high byte is read, so a carry between reads is harmless
  assign snap_next = rdHi ? routeWord : snap_reg;

  // ----------------------------------------
  // port select: honoured at any time, even mid drive
  // ----------------------------------------
  assign portSel_next = !(wrCmd && isSelect)        ? portSel_reg :
                        (regWrData == `CMD_SEL_COUNT) ? PORT_COUNT :
                        (regWrData == `CMD_SEL_SPEED) ? PORT_SPEED : PORT_CMP;

  // ----------------------------------------
  // drive sequencer
  // ----------------------------------------
  always_comb begin
    state_next    = state_reg;
    phase_next    = phase_reg;
    mode_next     = mode_reg;
    count_next    = count_reg;
    remain_next   = remain_reg;
    waitCnt_next  = waitCnt_reg;
    orgType_next  = orgType_reg;
    busy_next     = busy_reg;
    drive_next    = drive_reg;
    error_next    = error_reg;
    limitEnd_next = limitEnd_reg;
    fastEnd_next  = fastEnd_reg;
    dir_next      = dir_reg;
    lastStep_next = lastStep_reg;
    pulseCw_next  = 1'b0;
    pulseCcw_next = 1'b0;
    if (stopNow) begin
      fastEnd_next = 1'b1;
      drive_next   = 1'b0;
      busy_next    = 1'b0;
      state_next   = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          busy_next = 1'b0;
          if (wrCmd && !isSelect) begin
            error_next    = 1'b0;
            limitEnd_next = 1'b0;
            fastEnd_next  = 1'b0;
            busy_next     = 1'b1;
            if (isScan || isIndex || isOrigin) begin
              dir_next     = cmdDir;
              mode_next    = isScan ? MODE_SCAN : isIndex ? MODE_INDEX : MODE_ORIGIN;
              phase_next   = PH_SEEK;
              remain_next  = absDelta;
              orgType_next = dataHi_reg[2:0];
              if (cmdLimit) begin
                error_next = 1'b1;
              end else if (isIndex && absDelta == 24'h000000) begin
                busy_next = 1'b0;
              end else begin
                drive_next = 1'b1;
                state_next = (servoOn && driveEnd) ? ST_HOLD : ST_RUN;
              end
            end else if (!isSetup && regWrData != `CMD_FAST_STOP) begin
              error_next = 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (!driveEnd) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          if (runLimit && mode_reg == MODE_ORIGIN && phase_reg == PH_SEEK) begin
            dir_next     = !dir_reg;
            waitCnt_next = limitWait_reg;
            state_next   = ST_DELAY;
          end else if (runLimit) begin
            limitEnd_next = 1'b1;
            drive_next    = 1'b0;
            lastStep_next = 1'b1;
            state_next    = servoOn ? ST_SERVO_WAIT : ST_IDLE;
            busy_next     = servoOn;
          end else if (mode_reg == MODE_ORIGIN && phase_reg == PH_SEEK && sensorOn) begin
            phase_next    = PH_SENSED;
            waitCnt_next  = scanWait_reg;
            lastStep_next = 1'b0;
            state_next    = servoOn ? ST_SERVO_WAIT : ST_DELAY;
          end else if (stepTick) begin
            pulseCw_next  = !dir_reg;
            pulseCcw_next = dir_reg;
            count_next    = dir_reg ? count_reg - `WORD_ONE : count_reg + `WORD_ONE;
            if (counted) begin
              remain_next = remain_reg - `WORD_ONE;
              if (remain_reg == `WORD_ONE) begin
                drive_next    = 1'b0;
                lastStep_next = 1'b1;
                state_next    = servoOn ? ST_SERVO_WAIT : ST_IDLE;
                busy_next     = servoOn;
              end
            end
          end
        end
        ST_DELAY: begin
          if (waitCnt_reg == `DELAY_RESET) begin
            if (phase_reg == PH_SEEK) begin
              state_next = ST_RUN;
            end else if (phase_reg == PH_SENSED && type35) begin
              phase_next   = PH_JOG;
              waitCnt_next = jogWait_reg;
            end else if (phase_reg == PH_JOG) begin
              phase_next  = PH_FINAL;
              remain_next = `WORD_ONE;
              state_next  = ST_RUN;
            end else begin
              drive_next = 1'b0;
              busy_next  = 1'b0;
              state_next = ST_IDLE;
            end
          end else if (waitTick) begin
            waitCnt_next = waitCnt_reg - 8'h01;
          end
        end
        ST_SERVO_WAIT: begin
          // a drive-end that never comes parks the sequence here
          if (!driveEnd) begin
            state_next = lastStep_reg ? ST_IDLE : ST_DELAY;
            busy_next  = !lastStep_reg;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // setup commands only land when the sequencer is free
  wire setupOk = wrCmd && (state_reg == ST_IDLE);
  assign speed_next = (setupOk && regWrData == `CMD_SPEED_SET) ? dataWord : speed_reg;
  assign cmp_next   = (setupOk && regWrData == `CMD_CMP_SET) ? dataWord : cmp_reg;
  // a hit in the clearing cycle survives the clear
  assign match_next = (match_reg && !(setupOk && regWrData == `CMD_CMP_SET))
                      || (count_reg == cmp_reg);

  // ----------------------------------------
  // sequencer and counter flops
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= ST_IDLE;
      phase_reg    <= PH_SEEK;
      mode_reg     <= MODE_SCAN;
      count_reg    <= `COUNT_RESET;
      remain_reg   <= `COUNT_RESET;
      cmp_reg      <= `CMP_RESET;
      speed_reg    <= `SPEED_RESET;
      waitCnt_reg  <= `DELAY_RESET;
      orgType_reg  <= 3'h0;
      {busy_reg, drive_reg, error_reg, limitEnd_reg} <= 4'h0;
      {fastEnd_reg, match_reg, dir_reg, lastStep_reg} <= 4'h0;
      pulseCwOut   <= 1'b0;
      pulseCcwOut  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      phase_reg    <= phase_next;
      mode_reg     <= mode_next;
      count_reg    <= count_next;
      remain_reg   <= remain_next;
      cmp_reg      <= cmp_next;
      speed_reg    <= speed_next;
      waitCnt_reg  <= waitCnt_next;
      orgType_reg  <= orgType_next;
      {busy_reg, drive_reg, error_reg, limitEnd_reg} <=
        {busy_next, drive_next, error_next, limitEnd_next};
      {fastEnd_reg, match_reg, dir_reg, lastStep_reg} <=
        {fastEnd_next, match_next, dir_next, lastStep_next};
      pulseCwOut   <= pulseCw_next;
      pulseCcwOut  <= pulseCcw_next;
    end
  end

  // ----------------------------------------
  // register port flops
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {dataHi_reg, dataMid_reg, dataLo_reg} <= `COUNT_RESET;
      {limitWait_reg, scanWait_reg, jogWait_reg} <= `COUNT_RESET;
      cfg_reg     <= `CFG_RESET;
      portSel_reg <= PORT_COUNT;
      snap_reg    <= `COUNT_RESET;
      regRdData   <= `BYTE_ZERO;
    end else begin
      if (wrHi) dataHi_reg <= regWrData;
      if (wrMid) dataMid_reg <= regWrData;
      if (wrLo) dataLo_reg <= regWrData;
      if (wrCfg) cfg_reg <= regWrData;
      if (setupOk && regWrData == `CMD_ORG_DELAY) begin
        {limitWait_reg, scanWait_reg, jogWait_reg} <= dataWord;
      end
      portSel_reg <= portSel_next;
      snap_reg    <= snap_next;
      regRdData   <= regRdStrobe ? rdNext : `BYTE_ZERO;
    end
  end

endmodule

`default_nettype wire

// [dv/pulse_motor_props.sv]
// assertion checker for the pulse motor drive and status block
`timescale 1ns/10ps
`default_nettype none
`include "pulse_motor_consts.svh"

module pulse_motor_props (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrStrobe,
  input wire logic       regRdStrobe,
  input wire logic [7:0] regRdData,
  // motor pins
  input wire logic       limitCwIn,
  input wire logic       limitCcwIn,
  input wire logic       fastStopIn,
  input wire logic       originSensorIn,
  input wire logic       servoDriveEndIn,
  input wire logic       pulseCwOut,
  input wire logic       pulseCcwOut
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // port relations
  // ----------------------------------------
  // reset is checked while it is held, so it cannot disable itself
  reset_quiet_a: assert property (disable iff (1'b0)
    !resetn |-> !pulseCwOut && !pulseCcwOut && regRdData == 8'h00) else $error("output in reset");
  rd_idle_a: assert property (!$past(regRdStrobe) |-> regRdData == 8'h00)
    else $error("read data outside its cycle");
  unmapped_rd_a: assert property (regRdStrobe && regAddr > `ADDR_CFG |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  status_upper_a: assert property (regRdStrobe && regAddr == `ADDR_CMD |=>
    regRdData[7:6] == 2'b00) else $error("unused status bits set");
  // pins pass a two-stage synchroniser, so four samples cover the latency
  fast_quiet_a: assert property (fastStopIn [*4] |-> !pulseCwOut && !pulseCcwOut)
    else $error("pulse during fast stop");
  cw_limit_a: assert property (limitCwIn [*4] |-> !pulseCwOut)
    else $error("cw pulse at cw limit");
  ccw_limit_a: assert property (limitCcwIn [*4] |-> !pulseCcwOut)
    else $error("ccw pulse at ccw limit");
  pulse_excl_a: assert property (!(pulseCwOut && pulseCcwOut))
    else $error("both directions pulsed");

  // main scenarios
  cover property (regRdStrobe && regAddr == `ADDR_DATA_HI);
  cover property (pulseCwOut ##[1:100] servoDriveEndIn);
  cover property (pulseCcwOut ##[1:100] originSensorIn);
endmodule
`default_nettype wire

// [dv/motor_side_model.sv]
// motor and servo side model: axis position, servo settling, origin sensor
`timescale 1ns/10ps
`default_nettype none

module motor_side_model #(
  parameter int SETTLE = 12
) (
  // clock and step pulses from the controller
  input  wire logic               ref_clk,
  input  wire logic               pulseCwOut,
  input  wire logic               pulseCcwOut,
  // bench controls
  input  wire logic               holdEnd,
  input  wire logic signed [31:0] sensorAt,
  // pins back to the controller
  output logic                    servoDriveEndIn,
  output logic                    originSensorIn
);
  int pos    = 0;
  int settle = 0;
  // each step restarts settling, like a real servo lagging its command
  always @(posedge ref_clk) begin
    if (pulseCwOut) pos <= pos + 1;
    if (pulseCcwOut) pos <= pos - 1;
    settle <= (pulseCwOut || pulseCcwOut) ? SETTLE : (settle > 0 ? settle - 1 : 0);
  end
  assign servoDriveEndIn = holdEnd || settle != 0;
  // sensor area is every position at or below the edge
  assign originSensorIn = pos <= sensorAt;
endmodule
`default_nettype wire

// [dv/pulse_motor_drive_status_tb_top.sv]
// self-checking bench for the pulse motor drive and status block
`timescale 1ns/10ps
`default_nettype none
`include "pulse_motor_consts.svh"

module pulse_motor_drive_status_tb_top;
  logic               ref_clk = 1'b0;
  logic               resetn, regWrStrobe, regRdStrobe, holdEnd;
  logic               limitCwIn, limitCcwIn, fastStopIn;
  logic               originSensorIn, servoDriveEndIn, pulseCwOut, pulseCcwOut;
  logic [2:0]         regAddr;
  logic [7:0]         regWrData, regRdData, s;
  logic [23:0]        w, c0;
  logic signed [31:0] sensorAt;
  logic [7:0]         ty [3] = '{8'h03, 8'h05, 8'h00};
  int                 n_errors = 0;
  int                 n_checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  // short wait unit keeps origin delays to a few cycles
  pulse_motor_drive_status #(.WAIT_TICK_CYCLES(4)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .limitCwIn(limitCwIn), .limitCcwIn(limitCcwIn), .fastStopIn(fastStopIn),
    .originSensorIn(originSensorIn), .servoDriveEndIn(servoDriveEndIn),
    .pulseCwOut(pulseCwOut), .pulseCcwOut(pulseCcwOut));
  motor_side_model motor (
    .ref_clk(ref_clk), .pulseCwOut(pulseCwOut), .pulseCcwOut(pulseCcwOut),
    .holdEnd(holdEnd), .sensorAt(sensorAt), .servoDriveEndIn(servoDriveEndIn),
    .originSensorIn(originSensorIn));

  // ----------------------------------------
  // register port access and checks
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr     <= a;
    regWrData   <= d;
    regWrStrobe <= 1'b1;
    @(posedge ref_clk);
    regWrStrobe <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr     <= a;
    regRdStrobe <= 1'b1;
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic st(input string n, input logic [7:0] e);
    rd(`ADDR_CMD, s);
    chk(n, 24'(e), 24'(s));
  endtask
  task automatic cmd(input logic [7:0] c, input logic [23:0] v);
    wr(`ADDR_DATA_HI, v[23:16]);
    wr(`ADDR_DATA_MID, v[15:8]);
    wr(`ADDR_DATA_LO, v[7:0]);
    wr(`ADDR_CMD, c);
  endtask
  // high byte first, so the snapshot keeps the word coherent
  task automatic cnt(input logic [23:0] e);
    rd(`ADDR_DATA_HI, w[23:16]);
    rd(`ADDR_DATA_MID, w[15:8]);
    rd(`ADDR_DATA_LO, w[7:0]);
    chk("count", e, w);
  endtask
  task automatic waitLow(input int b);
    for (int i = 0; i < 4000; i++) begin
      rd(`ADDR_CMD, s);
      if (s[b] === 1'b0) return;
    end
    n_errors++;
    $display("CHECK FAILED status wait exp 0 got 1");
    report_and_stop();
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    // reset starts high and falls, so the flops see a real edge before the first clock
    {resetn, regWrStrobe, regRdStrobe, holdEnd} = 4'h8;
    {limitCwIn, limitCcwIn, fastStopIn} = 3'h0;
    regAddr   = 3'h0;
    regWrData = 8'h00;
    sensorAt  = -1000;
    #1 resetn = 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    st("reset status", 8'h00);
    cnt(24'h000000);
    rd(3'h5, s);
    chk("unmapped", 24'h000000, 24'(s));
    wr(`ADDR_CMD, `CMD_SEL_CMP);
    cnt(24'h800000);
    wr(`ADDR_CMD, `CMD_SEL_COUNT);
    // an unknown code is refused with the error flag; the next command clears it
    wr(`ADDR_CMD, 8'h77);
    st("bad command", 8'h04);
    cmd(`CMD_SPEED_SET, 24'h000002);
    cmd(`CMD_INDEX_INC, 24'h000005);
    st("index busy", 8'h03);
    waitLow(`STAT_BUSY);
    cnt(24'h000005);
    cmd(`CMD_INDEX_INC, 24'hFFFFF9);
    waitLow(`STAT_BUSY);
    cnt(24'hFFFFFE);
    wr(`ADDR_CMD, `CMD_SEL_SPEED);
    cnt(24'h000002);
    wr(`ADDR_CMD, `CMD_SEL_COUNT);
    cnt(24'hFFFFFE);
    cmd(`CMD_INDEX_ABS, 24'hFFFFFE);
    st("zero index", 8'h00);
    // scans end only on a stop or a limit; here on a stop: pin first, then the command
    for (int k = 0; k < 2; k++) begin
      cmd(k ? `CMD_SCAN_CCW : `CMD_SCAN_CW, 24'h000000);
      repeat (40) @(posedge ref_clk);
      if (k) wr(`ADDR_CMD, `CMD_FAST_STOP);
      else fastStopIn <= 1'b1;
      repeat (6) @(posedge ref_clk);
      fastStopIn <= 1'b0;
      st("fast stop", 8'h10);
      cnt(24'(motor.pos));
    end
    limitCwIn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cmd(`CMD_SCAN_CW, 24'h000000);
    st("limit refuse", 8'h04);
    limitCwIn <= 1'b0;
    cmd(`CMD_SCAN_CCW, 24'h000000);
    repeat (40) @(posedge ref_clk);
    limitCcwIn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    st("limit end", 8'h08);
    limitCcwIn <= 1'b0;
    wr(`ADDR_CFG, 8'h01);
    holdEnd <= 1'b1;
    c0 = 24'(motor.pos);
    cmd(`CMD_INDEX_INC, 24'h000003);
    repeat (20) @(posedge ref_clk);
    st("servo hold", 8'h03);
    cnt(c0);
    holdEnd <= 1'b0;
    waitLow(`STAT_DRIVE);
    st("servo settle", 8'h01);
    waitLow(`STAT_BUSY);
    cnt(c0 + 24'h000003);
    wr(`ADDR_CFG, 8'h00);
    cmd(`CMD_ORG_DELAY, 24'h010101);
    cmd(`CMD_SPEED_SET, 24'h000014);
    // slow steps keep the sensor latency well inside one step
    for (int t = 0; t < 3; t++) begin
      // the last origin runs in servo mode, waiting for drive-end at the sensor
      wr(`ADDR_CFG, {7'h00, t == 2});
      c0 = 24'(motor.pos - ((t < 2) ? 5 : 4));
      sensorAt <= motor.pos - 4;
      cmd(`CMD_ORIGIN, {ty[t], 16'h0000});
      waitLow(`STAT_BUSY);
      cnt(c0);
      cmd(`CMD_INDEX_INC, 24'h00000A);
      waitLow(`STAT_BUSY);
    end
    report_and_stop();
  end
endmodule

bind pulse_motor_drive_status pulse_motor_props props (
  .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
  .limitCwIn(limitCwIn), .limitCcwIn(limitCcwIn), .fastStopIn(fastStopIn),
  .originSensorIn(originSensorIn), .servoDriveEndIn(servoDriveEndIn),
  .pulseCwOut(pulseCwOut), .pulseCcwOut(pulseCcwOut));
`default_nettype wire
